/* File: logic/ffa_fault_flag_aggregator.sv */
// ffa_fault_flag_aggregator: latched fault flag register with modem and supply summaries
// assumes detector inputs are one-clock or level conditions synchronous to clk_sys_in
`timescale 1ns/100ps
module ffa_fault_flag_aggregator (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [ffa_pkg::FFA_ADDR_W-1:0] addr_in,
    input wire logic [ffa_pkg::FFA_DATA_W-1:0] wr_data_in,
    input wire logic [ffa_pkg::FFA_MODEM_W-1:0] modem_fault_sources_in,
    input wire logic [ffa_pkg::FFA_MODEM_W-1:0] modem_fault_mask_in,
    input wire logic [ffa_pkg::FFA_SUPPLY_W-1:0] supply_status_in,
    input wire logic [ffa_pkg::FFA_SUPPLY_W-1:0] supply_mask_in,
    input wire logic analog_open_in,
    input wire logic analog_short_in,
    input wire logic int_output_short_expiry_in,
    input wire logic ext_output_short_expiry_in,
    input wire logic int_output_short_in,
    input wire logic ext_output_short_in,
    input wire logic initial_drive_period_in,
    input wire logic output_overheat_restart_in,
    input wire logic input_open_in,
    input wire logic input_short_in,
    input wire logic conv_error_in,
    input wire logic conv_saturation_in,
    input wire logic overtemp_in,
    input wire logic power_ctl_busy_fault_in,
    input wire logic power_ctl_ack_fault_in,
    input wire logic serial_clock_count_error_in,
    input wire logic serial_crc_error_in,
    output logic [ffa_pkg::FFA_DATA_W-1:0] fault_flag_register_out,
    output logic [ffa_pkg::FFA_DATA_W-1:0] live_view_out,
    output logic fault_request_out,
    output logic int_output_disable_out,
    output logic ext_output_disable_out
);
    import ffa_pkg::*;

    // ------------------------------------------------------------
    // source decode
    // ------------------------------------------------------------
    function automatic logic any_unmasked(input logic [15:0] src, input logic [15:0] msk);
        any_unmasked = |(src & ~msk);
    endfunction : any_unmasked

    logic [15:0] cond;
    logic wr_flag;
    logic [15:0] clr;

    always_comb begin
        cond = 16'h0000;
        cond[B_MODEM] = any_unmasked(modem_fault_sources_in & ~FFA_MODEM_EXCLUDE,
            modem_fault_mask_in);
        cond[B_AOPEN] = analog_open_in;
        cond[B_ASHORT] = analog_short_in;
        cond[B_INT_EXP] = int_output_short_expiry_in;
        cond[B_EXT_EXP] = ext_output_short_expiry_in;
        cond[B_INT_SC] = int_output_short_in & ~initial_drive_period_in;
        cond[B_EXT_SC] = ext_output_short_in & ~initial_drive_period_in;
        cond[B_THERM] = output_overheat_restart_in;
        cond[B_IOPEN] = input_open_in;
        cond[B_ISHORT] = input_short_in;
        cond[B_CONV] = conv_error_in | conv_saturation_in;
        cond[B_TEMP] = overtemp_in;
        cond[B_PWR] = power_ctl_busy_fault_in | power_ctl_ack_fault_in;
        cond[B_SER] = serial_clock_count_error_in | serial_crc_error_in;
        cond[B_SUPPLY] = any_unmasked(supply_status_in, supply_mask_in);
    end

    // ------------------------------------------------------------
    // flag register
    // ------------------------------------------------------------
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] live_q;
    logic [15:0] live_d;
    logic req_q;
    logic req_d;
    logic int_dis_q;
    logic int_dis_d;
    logic ext_dis_q;
    logic ext_dis_d;

    always_comb begin
        wr_flag = wr_en_in && (addr_in == FFA_FAULT_FLAG_ADDR);
        // clear needs a written one and the cause gone; a live cause wins
        clr = wr_flag ? (wr_data_in & FFA_W1C_MASK & ~cond) : 16'h0000;
        flags_d = ((flags_q & ~clr) | cond) & FFA_W1C_MASK;
        flags_d[B_MODEM] = cond[B_MODEM];
        flags_d[B_SUPPLY] = cond[B_SUPPLY];
        live_d = cond & ~(16'h1 << B_MODEM) & ~(16'h1 << B_RESET);
        live_d[B_INT_EXP] = 1'b0;
        live_d[B_EXT_EXP] = 1'b0;
        live_d[B_CONV] = 1'b0;
        live_d[B_PWR] = 1'b0;
        live_d[B_SER] = 1'b0;
        req_d = |flags_d;
        int_dis_d = flags_d[B_INT_EXP];
        ext_dis_d = flags_d[B_EXT_EXP];
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            flags_q <= FFA_FAULT_FLAG_RESET;
            live_q <= FFA_LIVE_VIEW_RESET;
            req_q <= 1'b1;
            int_dis_q <= 1'b0;
            ext_dis_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            live_q <= live_d;
            req_q <= req_d;
            int_dis_q <= int_dis_d;
            ext_dis_q <= ext_dis_d;
        end
    end

    assign fault_flag_register_out = flags_q;
    assign live_view_out = live_q;
    assign fault_request_out = req_q;
    assign int_output_disable_out = int_dis_q;
    assign ext_output_disable_out = ext_dis_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence s_clear_write(int b);
        wr_flag && wr_data_in[b] && !cond[b];
    endsequence

    chk_flag_sticky: assert property (
        flags_q[B_AOPEN] && !(wr_flag && wr_data_in[B_AOPEN]) |=> flags_q[B_AOPEN])
        else $error("open flag dropped without clear");
    chk_flag_clear: assert property (
        s_clear_write(B_ASHORT) |=> !flags_q[B_ASHORT])
        else $error("short flag not cleared by write one");
    chk_reset_flag_req: assert property (
        flags_q[B_RESET] |-> fault_request_out)
        else $error("reset flag without fault request");
    chk_reset_clear: assert property (
        $fell(flags_q[B_RESET]) |-> $past(wr_flag && wr_data_in[B_RESET]))
        else $error("reset flag cleared without write");
    chk_modem_sum: assert property (
        |(modem_fault_sources_in & ~FFA_MODEM_EXCLUDE & ~modem_fault_mask_in)
            |=> flags_q[B_MODEM])
        else $error("modem summary missing");
    chk_modem_self: assert property (
        !(|(modem_fault_sources_in & ~FFA_MODEM_EXCLUDE & ~modem_fault_mask_in))
            |=> !flags_q[B_MODEM])
        else $error("modem summary stuck");
    chk_supply_sum: assert property (
        |(supply_status_in & ~supply_mask_in) |=> flags_q[B_SUPPLY])
        else $error("supply summary missing");
    chk_supply_self: assert property (
        !(|(supply_status_in & ~supply_mask_in)) |=> !flags_q[B_SUPPLY])
        else $error("supply summary stuck");
    chk_int_expiry: assert property (
        int_output_short_expiry_in |=> flags_q[B_INT_EXP] && int_output_disable_out)
        else $error("internal expiry not latched or output not disabled");
    chk_ext_expiry: assert property (
        ext_output_short_expiry_in |=> flags_q[B_EXT_EXP] && ext_output_disable_out)
        else $error("external expiry not latched or output not disabled");
    chk_short_blank: assert property (
        initial_drive_period_in && !flags_q[B_INT_SC] && !wr_flag |=> !flags_q[B_INT_SC])
        else $error("short flag raised during initial drive period");
    chk_pwr_fault: assert property (
        power_ctl_busy_fault_in || power_ctl_ack_fault_in |=> flags_q[B_PWR])
        else $error("power control fault not latched");
    chk_serial_fault: assert property (
        serial_clock_count_error_in || serial_crc_error_in |=> flags_q[B_SER])
        else $error("serial fault not latched");
    chk_temp_fault: assert property (
        overtemp_in |=> flags_q[B_TEMP] && live_view_out[B_TEMP])
        else $error("overtemperature not latched");

    // ------------------------------------------------------------
    // checks: single-cause flags and the two-cause converter flag
    // ------------------------------------------------------------
    chk_analog_open: assert property (
        analog_open_in |=> flags_q[B_AOPEN] && live_view_out[B_AOPEN])
        else $error("analog open not latched");

    chk_analog_short: assert property (
        analog_short_in |=> flags_q[B_ASHORT] && live_view_out[B_ASHORT])
        else $error("analog short not latched");

    chk_overheat_flag: assert property (
        output_overheat_restart_in |=> flags_q[B_THERM] && live_view_out[B_THERM])
        else $error("overheat restart not latched");

    chk_input_open: assert property (
        input_open_in |=> flags_q[B_IOPEN] && live_view_out[B_IOPEN])
        else $error("input open not latched");

    chk_input_short: assert property (
        input_short_in |=> flags_q[B_ISHORT] && live_view_out[B_ISHORT])
        else $error("input short not latched");

    chk_conv_fault: assert property (
        conv_error_in || conv_saturation_in |=> flags_q[B_CONV])
        else $error("converter fault not latched");

    // ------------------------------------------------------------
    // checks: clearing and blanking
    // ------------------------------------------------------------
    sequence s_live_cause_write(int b);
        wr_flag && wr_data_in[b] && cond[b];
    endsequence

    chk_clear_refused: assert property (
        s_live_cause_write(B_IOPEN) |=> flags_q[B_IOPEN])
        else $error("flag cleared while cause still present");

    chk_other_addr: assert property (
        wr_en_in && (addr_in != FFA_FAULT_FLAG_ADDR) && flags_q[B_TEMP] |=> flags_q[B_TEMP])
        else $error("write to another address cleared a flag");

    chk_reset_hold: assert property (
        flags_q[B_RESET] && !(wr_flag && wr_data_in[B_RESET]) |=> flags_q[B_RESET])
        else $error("reset flag dropped without write");

    chk_reset_write: assert property (
        wr_flag && wr_data_in[B_RESET] |=> !flags_q[B_RESET])
        else $error("reset flag not cleared by write one");

    chk_ext_blank: assert property (
        initial_drive_period_in && !flags_q[B_EXT_SC] && !wr_flag |=> !flags_q[B_EXT_SC])
        else $error("external short flag raised during initial drive period");

    chk_int_short_set: assert property (
        int_output_short_in && !initial_drive_period_in |=> flags_q[B_INT_SC])
        else $error("internal short not latched");

    chk_ext_short_set: assert property (
        ext_output_short_in && !initial_drive_period_in |=> flags_q[B_EXT_SC])
        else $error("external short not latched");

    chk_modem_nowrite: assert property (
        wr_flag && wr_data_in[B_MODEM]
            && |(modem_fault_sources_in & ~FFA_MODEM_EXCLUDE & ~modem_fault_mask_in)
            |=> flags_q[B_MODEM])
        else $error("write cleared modem summary");

    chk_supply_nowrite: assert property (
        wr_flag && wr_data_in[B_SUPPLY] && |(supply_status_in & ~supply_mask_in)
            |=> flags_q[B_SUPPLY])
        else $error("write cleared supply summary");

    // ------------------------------------------------------------
    // checks: outputs and live view
    // ------------------------------------------------------------
    sequence s_int_expiry_cleared;
        int_output_short_expiry_in ##1
            (!int_output_short_expiry_in && wr_flag && wr_data_in[B_INT_EXP]);
    endsequence

    sequence s_ext_expiry_cleared;
        ext_output_short_expiry_in ##1
            (!ext_output_short_expiry_in && wr_flag && wr_data_in[B_EXT_EXP]);
    endsequence

    sequence s_input_short_pulse;
        input_short_in ##1 !input_short_in;
    endsequence

    chk_int_release: assert property (
        s_int_expiry_cleared |=> !int_output_disable_out)
        else $error("internal output still disabled after clear");

    chk_ext_release: assert property (
        s_ext_expiry_cleared |=> !ext_output_disable_out)
        else $error("external output still disabled after clear");

    chk_live_release: assert property (
        s_input_short_pulse |-> live_view_out[B_ISHORT] ##1 !live_view_out[B_ISHORT])
        else $error("live view held a condition that went away");

    chk_live_supply: assert property (
        |(supply_status_in & ~supply_mask_in) |=> live_view_out[B_SUPPLY])
        else $error("live view missing supply condition");

    chk_request_idle: assert property (
        !(|fault_flag_register_out) |-> !fault_request_out)
        else $error("fault request with no flag set");
endmodule : ffa_fault_flag_aggregator

/* File: logic/ffa_pkg.sv */
// ffa_pkg: register offsets, field positions and reset values of the fault flag aggregator
// assumes a 16-bit register port with a 7-bit address, as used by the host serial logic
package ffa_pkg;
    localparam int FFA_ADDR_W = 7;
    localparam int FFA_DATA_W = 16;
    localparam logic [6:0] FFA_FAULT_FLAG_ADDR = 7'h41;
    localparam logic [6:0] FFA_LIVE_VIEW_ADDR = 7'h42;
    localparam logic [15:0] FFA_FAULT_FLAG_RESET = 16'h0001;
    localparam logic [15:0] FFA_LIVE_VIEW_RESET = 16'h0000;
    localparam int FFA_MODEM_W = 16;
    localparam int FFA_SUPPLY_W = 16;
    // modem source bits that never feed the summary
    localparam logic [15:0] FFA_MODEM_EXCLUDE = 16'h0003;
    localparam int B_MODEM = 15;
    localparam int B_AOPEN = 14;
    localparam int B_ASHORT = 13;
    localparam int B_INT_EXP = 12;
    localparam int B_EXT_EXP = 11;
    localparam int B_INT_SC = 10;
    localparam int B_EXT_SC = 9;
    localparam int B_THERM = 8;
    localparam int B_IOPEN = 7;
    localparam int B_ISHORT = 6;
    localparam int B_CONV = 5;
    localparam int B_TEMP = 4;
    localparam int B_PWR = 3;
    localparam int B_SER = 2;
    localparam int B_SUPPLY = 1;
    localparam int B_RESET = 0;
    // bits that hold latched, write-one-to-clear flags
    localparam logic [15:0] FFA_W1C_MASK = 16'h7FFD;
endpackage : ffa_pkg

/* File: testbench/ffa_testbench.sv */
// ffa_testbench: random and directed stimulus compared with a behavioural flag model
// assumes ffa_fault_flag_aggregator and ffa_pkg compiled first; asserts live in the design
`timescale 1ns/100ps
module testbench;
    import ffa_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_en_in = 1'b0;
    logic [6:0] addr_in = 7'h00;
    logic [15:0] wr_data_in = 16'h0000;
    logic [15:0] msrc = 16'h0000;
    logic [15:0] mmask = 16'h0000;
    logic [15:0] ssrc = 16'h0000;
    logic [15:0] smask = 16'h0000;
    logic [15:0] det = 16'h0000;
    logic idp = 1'b0;
    logic [15:0] flags, live, exp_q, live_q, set_v, nx;
    logic req, dis_i, dis_e, req_q, sup;
    logic [31:0] r = 32'hE539DDE2;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    // ---------------------------------------------------------------
    // clock, dut
    // ---------------------------------------------------------------
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    ffa_fault_flag_aggregator u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .wr_en_in(wr_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .modem_fault_sources_in(msrc), .modem_fault_mask_in(mmask),
        .supply_status_in(ssrc), .supply_mask_in(smask),
        .analog_open_in(det[0]), .analog_short_in(det[1]),
        .int_output_short_expiry_in(det[2]), .ext_output_short_expiry_in(det[3]),
        .int_output_short_in(det[4]), .ext_output_short_in(det[5]),
        .initial_drive_period_in(idp), .output_overheat_restart_in(det[6]),
        .input_open_in(det[7]), .input_short_in(det[8]), .conv_error_in(det[9]),
        .conv_saturation_in(det[10]), .overtemp_in(det[11]),
        .power_ctl_busy_fault_in(det[12]), .power_ctl_ack_fault_in(det[13]),
        .serial_clock_count_error_in(det[14]), .serial_crc_error_in(det[15]),
        .fault_flag_register_out(flags), .live_view_out(live), .fault_request_out(req),
        .int_output_disable_out(dis_i), .ext_output_disable_out(dis_e));
    // ---------------------------------------------------------------
    // reference model
    // ---------------------------------------------------------------
    always_comb begin
        set_v = {1'b0, det[0], det[1], det[2], det[3], det[4] & ~idp, det[5] & ~idp, det[6],
            det[7], det[8], det[9] | det[10], det[11], det[12] | det[13], det[14] | det[15],
            2'b00};
        sup = |(ssrc & ~smask);
        nx = exp_q & ~((wr_en_in && addr_in == FFA_FAULT_FLAG_ADDR) ? wr_data_in & FFA_W1C_MASK
            : 16'h0000) | set_v;
        nx[15] = |(msrc & ~mmask & ~FFA_MODEM_EXCLUDE);
        nx[1] = sup;
    end
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            exp_q <= FFA_FAULT_FLAG_RESET;
            live_q <= 16'h0000;
            req_q <= 1'b1;
        end else begin
            exp_q <= nx;
            live_q <= (set_v & 16'h67D0) | {14'h0000, sup, 1'b0};
            req_q <= |nx;
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic step(input bit hold);
        @(negedge clk_sys_in);
        check(flags, exp_q);
        check(live, live_q);
        check({15'h0000, req}, {15'h0000, req_q});
        check({14'h0000, dis_i, dis_e}, {14'h0000, exp_q[12], exp_q[11]});
        r = lfsr(r);
        det <= hold ? 16'h0001 : r[15:0] & r[31:16] & {r[7:0], r[15:8]};
        idp <= r[20];
        wr_en_in <= hold | r[3];
        addr_in <= (hold | r[9]) ? FFA_FAULT_FLAG_ADDR : r[30:24];
        wr_data_in <= (hold | r[2]) ? 16'hFFFF : r[31:16];
        r = lfsr(r);
        msrc <= r[15:0] & r[31:16];
        mmask <= {r[23:16], r[31:24]} | {r[7:0], r[15:8]};
        r = lfsr(r);
        ssrc <= r[15:0] & r[31:16] & {r[7:0], r[15:8]};
        smask <= r[31:16] & {r[7:0], r[15:8]};
    endtask : step
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    // ---------------------------------------------------------------
    // sequence and timeout
    // ---------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up;
        end
    end
    initial begin
        repeat (6) @(negedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (3000) step(1'b0);
        repeat (4) step(1'b1);
        rst_in <= 1'b1;
        repeat (3) step(1'b0);
        rst_in <= 1'b0;
        repeat (1500) step(1'b0);
        wrap_up;
    end
endmodule : testbench
